// ### dv/i2c_master_model.sv
`timescale 1ns/1ns

module i2c_master_model (
   input wire logic                       clk_sys,
   output i2c_slave_event_pkg::event_vec_t events
);
   import i2c_slave_event_pkg::*;
   // ==========================================
   // engine strobes seen from the bus side
   initial events = '0;
   task automatic fire(input int k);
      events <= event_vec_t'(6'h1 << k);
      @(posedge clk_sys);
      events <= '0;
   endtask
endmodule

// ### dv/i2c_slave_event_irq_regs_asserts.sv
`timescale 1ns/1ns
`include "i2c_slave_event_irq_regs.svh"

module i2c_slave_event_irq_regs_asserts #(
   parameter int ADDR_W = 12
) (
   input wire logic                            clk_sys,
   input wire logic                            rst_n,
   input wire logic [ADDR_W-1:0]               bus_addr,
   input wire logic [31:0]                     wr_data,
   input wire logic                            wr_stb,
   input wire logic                            rd_stb,
   input wire logic [31:0]                     rd_data,
   input wire i2c_slave_event_pkg::event_vec_t events,
   input wire i2c_slave_event_pkg::task_req_t  task_req,
   input wire logic [31:0]                     event_task_shortcuts,
   input wire logic                            irq
);
   import i2c_slave_event_pkg::*;
   // ==========================================
   // properties
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sequence s_rd(ofs);
      rd_stb && bus_addr == ofs;
   endsequence
   sequence s_en(val);
      wr_stb && bus_addr == `OFS_INT_ENABLE && wr_data == val;
   endsequence

   property p_suspend;
      task_req.suspend == ((events.write_cmd && event_task_shortcuts[`BIT_WRITE_SUSPEND])
                        || (events.read_cmd && event_task_shortcuts[`BIT_READ_SUSPEND]));
   endproperty
   property p_rx_flag;
      events.receive_sequence_begun ##1 s_rd(`OFS_RX_BEGUN_FLAG) |=> rd_data == 32'h1;
   endproperty
   property p_tx_flag;
      events.transmit_sequence_begun ##1 s_rd(`OFS_TX_BEGUN_FLAG) |=> rd_data == 32'h1;
   endproperty
   property p_wr_flag;
      events.write_cmd ##1 s_rd(`OFS_WRITE_CMD_FLAG) |=> rd_data == 32'h1;
   endproperty
   property p_rd_flag;
      events.read_cmd ##1 s_rd(`OFS_READ_CMD_FLAG) |=> rd_data == 32'h1;
   endproperty
   property p_irq_off;
      s_en(32'h0) |=> !irq;
   endproperty
   property p_stop_irq;
      s_en(32'h2) ##1 (events.stopped && !wr_stb) |=> irq;
   endproperty
   property p_rx_irq;
      s_en(32'h0008_0000) ##1 (events.receive_sequence_begun && !wr_stb) |=> irq;
   endproperty

   a_suspend: assert property (p_suspend) else $error("suspend request wrong");
   a_rx_flag: assert property (p_rx_flag) else $error("rx begun flag not set");
   a_tx_flag: assert property (p_tx_flag) else $error("tx begun flag not set");
   a_wr_flag: assert property (p_wr_flag) else $error("write flag not set");
   a_rd_flag: assert property (p_rd_flag) else $error("read flag not set");
   a_irq_off: assert property (p_irq_off) else $error("irq with no enable");
   a_stop_irq: assert property (p_stop_irq) else $error("stopped irq missing");
   a_rx_irq: assert property (p_rx_irq) else $error("rx irq missing");
endmodule

// ### dv/i2c_slave_event_irq_regs_tb.sv
`timescale 1ns/1ns
`include "i2c_slave_event_irq_regs.svh"

module i2c_slave_event_irq_regs_tb;
   import i2c_slave_event_pkg::*;
   logic        clk_sys, rst_n, wr_stb, rd_stb, irq, chk_now;
   logic [11:0] bus_addr;
   logic [31:0] wr_data, rd_data, event_task_shortcuts, exp_now, exp_next;
   event_vec_t  events;
   task_req_t   task_req;
   int          fail_count, tests_run;
   logic [11:0] regs [10] = '{`OFS_STOPPED_FLAG, `OFS_ERROR_FLAG, `OFS_RX_BEGUN_FLAG, `OFS_TX_BEGUN_FLAG,
      `OFS_WRITE_CMD_FLAG, `OFS_READ_CMD_FLAG, `OFS_SHORTCUTS, `OFS_INT_ENABLE, `OFS_INT_STATUS, 12'h400};
   logic [4:0]  bitpos [6] = '{`BIT_STOPPED, `BIT_ERROR, `BIT_RX_BEGUN, `BIT_TX_BEGUN, `BIT_WRITE_CMD,
      `BIT_READ_CMD};

   i2c_slave_event_irq_regs DUT (.clk_sys(clk_sys), .rst_n(rst_n), .bus_addr(bus_addr), .wr_data(wr_data),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .events(events), .task_req(task_req),
      .event_task_shortcuts(event_task_shortcuts), .irq(irq));
   i2c_master_model u_master (.clk_sys(clk_sys), .events(events));

   // ==========================================
   // bus tasks and checking
   initial begin
      clk_sys = 0;
      forever #4 clk_sys = ~clk_sys;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus_addr <= a;
      wr_data <= d;
      wr_stb <= 1;
      rd_stb <= 0;
      @(posedge clk_sys);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      bus_addr <= a;
      exp_next <= e;
      rd_stb <= 1;
      wr_stb <= 0;
      @(posedge clk_sys);
   endtask
   task automatic ev(input int k);
      wr_stb <= 0;
      rd_stb <= 0;
      u_master.fire(k);
   endtask
   task automatic conclude;
      $display("tests %0d failures %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // read data stand in the cycle after the strobe
   always @(posedge clk_sys) begin
      if (chk_now === 1'b1) chk(rd_data, exp_now);
      chk_now <= rd_stb;
      exp_now <= exp_next;
   end
   initial begin
      repeat (2000) @(posedge clk_sys);
      fail_count++;
      conclude;
   end

   // ==========================================
   // tests
   initial begin
      rst_n = 0;
      wr_stb = 0;
      rd_stb = 0;
      bus_addr = '0;
      wr_data = '0;
      exp_next = '0;
      chk_now = 0;
      repeat (8) @(posedge clk_sys);
      rst_n <= 1;
      @(posedge clk_sys);
      chk(irq, 0);
      foreach (regs[i]) rd(regs[i], `RST_WORD);
      wr(`OFS_SHORTCUTS, '1);
      rd(`OFS_SHORTCUTS, `MASK_SHORTCUTS);
      chk(event_task_shortcuts, `MASK_SHORTCUTS);
      wr(`OFS_INT_ENABLE, '1);
      wr(12'h400, '1);
      rd(`OFS_INT_ENABLE, `MASK_INT_LAYOUT);
      rd(12'h400, 0);
      for (int k = 0; k < 6; k++) begin
         wr(`OFS_INT_ENABLE, 32'h1 << bitpos[k]);
         ev(k);
         chk(task_req.suspend, k >= 4);
         rd(regs[k], 1);
         chk(irq, 1);
         wr(`OFS_INT_ENABLE, 0);
         wr(regs[k], 0);
         chk(irq, 0);
         rd(regs[k], 0);
      end
      ev(3);
      rd(`OFS_INT_STATUS, 32'h1 << `BIT_TX_BEGUN);
      wr(`OFS_INT_STATUS, 32'h1 << `BIT_TX_BEGUN);
      rd(`OFS_TX_BEGUN_FLAG, 0);
      // event and clear in one cycle
      bus_addr <= `OFS_INT_STATUS;
      wr_data <= 32'h1 << `BIT_STOPPED;
      wr_stb <= 1;
      rd_stb <= 0;
      u_master.fire(0);
      rd(`OFS_STOPPED_FLAG, 1);
      wr(12'h400, 0);
      @(posedge clk_sys);
      conclude;
   end
endmodule

bind i2c_slave_event_irq_regs i2c_slave_event_irq_regs_asserts #(.ADDR_W(ADDR_W)) u_chk (.clk_sys(clk_sys),
   .rst_n(rst_n), .bus_addr(bus_addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
   .events(events), .task_req(task_req), .event_task_shortcuts(event_task_shortcuts), .irq(irq));

// ### verilog/event_flag_cell.sv
`timescale 1ns/1ns
`include "i2c_slave_event_irq_regs.svh"

module event_flag_cell (
   input  wire logic clk_sys,
   input  wire logic rst_n,
   input  wire logic set_pulse,
   input  wire logic load,
   input  wire logic load_val,
   input  wire logic clear,
   output logic      flag
);

   // hardware set wins over any software write or clear
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         flag <= `RST_FLAG;
      end else if (set_pulse) begin
         flag <= 1'b1;
      end else if (clear) begin
         flag <= 1'b0;
      end else if (load) begin
         flag <= load_val;
      end
   end

endmodule

// ### verilog/i2c_slave_event_irq_regs.sv
// Functional notes
// [RULE1] Receive-begun and transmit-begun flags are set by their events, read and written by software, zero after reset.
// [RULE2] One enable bit each for the stopped and error events lets or blocks their interrupt.
// [RULE3] Separate enable bits for receive-begun and transmit-begun, 1 enables, all enables reset to zero.
// [RULE4] The write-command flag is set when the master addresses a write and its interrupt is gated by its enable.
// [RULE5] The read-command flag is set when the master addresses a read and its interrupt is gated by its enable.
// [RULE6] Two shortcut bits make write-command or read-command trigger suspend; both reset to disabled.
// [RULE7] The interrupt line is high while any flag is 1 with its enable set, low otherwise.
`timescale 1ns/1ns
`include "i2c_slave_event_irq_regs.svh"

module i2c_slave_event_irq_regs #(
   parameter int ADDR_W = 12
) (
   input  wire logic                            clk_sys,
   input  wire logic                            rst_n,
   input  wire logic [ADDR_W-1:0]               bus_addr,
   input  wire logic [31:0]                     wr_data,
   input  wire logic                            wr_stb,
   input  wire logic                            rd_stb,
   output logic [31:0]                          rd_data,
   input  wire i2c_slave_event_pkg::event_vec_t events,
   output i2c_slave_event_pkg::task_req_t       task_req,
   output logic [31:0]                          event_task_shortcuts,
   output logic                                 irq
);
   import i2c_slave_event_pkg::*;

   // ==========================================
   // per-event constants
   function automatic logic [ADDR_W-1:0] event_offset(input int idx);
      logic [ADDR_W-1:0] ofs;
      ofs = '0;
      case (idx)
         0: begin
            ofs = ADDR_W'(`OFS_STOPPED_FLAG);
         end
         1: begin
            ofs = ADDR_W'(`OFS_ERROR_FLAG);
         end
         2: begin
            ofs = ADDR_W'(`OFS_RX_BEGUN_FLAG);
         end
         3: begin
            ofs = ADDR_W'(`OFS_TX_BEGUN_FLAG);
         end
         4: begin
            ofs = ADDR_W'(`OFS_WRITE_CMD_FLAG);
         end
         5: begin
            ofs = ADDR_W'(`OFS_READ_CMD_FLAG);
         end
         default: begin
            ofs = '0;
         end
      endcase
      return ofs;
   endfunction

   function automatic logic [4:0] event_bit(input int idx);
      logic [4:0] pos;
      pos = '0;
      case (idx)
         0: begin
            pos = `BIT_STOPPED;
         end
         1: begin
            pos = `BIT_ERROR;
         end
         2: begin
            pos = `BIT_RX_BEGUN;
         end
         3: begin
            pos = `BIT_TX_BEGUN;
         end
         4: begin
            pos = `BIT_WRITE_CMD;
         end
         5: begin
            pos = `BIT_READ_CMD;
         end
         default: begin
            pos = '0;
         end
      endcase
      return pos;
   endfunction

   // ==========================================
   // address decode
   wire logic                    hit_shortcuts;
   wire logic                    hit_int_enable;
   wire logic                    hit_int_status;
   wire logic [`EVENT_COUNT-1:0] hit_flag;
   wire logic                    hit_any;

   assign hit_shortcuts  = (bus_addr == ADDR_W'(`OFS_SHORTCUTS));
   assign hit_int_enable = (bus_addr == ADDR_W'(`OFS_INT_ENABLE));
   assign hit_int_status = (bus_addr == ADDR_W'(`OFS_INT_STATUS));
   assign hit_any        = hit_shortcuts | hit_int_enable | hit_int_status | (|hit_flag);

   wire logic                    wr_shortcuts;
   wire logic                    wr_int_enable;
   wire logic                    wr_int_status;

   assign wr_shortcuts   = wr_stb & hit_shortcuts;
   assign wr_int_enable  = wr_stb & hit_int_enable;
   assign wr_int_status  = wr_stb & hit_int_status;

   // ==========================================
   // event strobes in index order
   wire logic [`EVENT_COUNT-1:0] event_pulse;

   assign event_pulse = events;

   // ==========================================
   // event flags
   wire logic [`EVENT_COUNT-1:0] flag;
   wire logic [`EVENT_COUNT-1:0] flag_load;
   wire logic [`EVENT_COUNT-1:0] flag_w1c;

   genvar g;
   generate
      for (g = 0; g < `EVENT_COUNT; g++) begin : g_event
         assign hit_flag[g]  = (bus_addr == event_offset(g));
         // direct write of the flag register stores bit 0
         assign flag_load[g] = wr_stb & hit_flag[g];
         // writing one to the status layout clears the flag
         assign flag_w1c[g]  = wr_int_status & wr_data[event_bit(g)];

         // [RULE1] event sets flag
         // [RULE4] write command flag
         // [RULE5] read command flag
         event_flag_cell u_flag (
            .clk_sys   (clk_sys),
            .rst_n     (rst_n),
            .set_pulse (event_pulse[g]),
            .load      (flag_load[g]),
            .load_val  (wr_data[`BIT_FLAG_VALUE]),
            .clear     (flag_w1c[g]),
            .flag      (flag[g])
         );
      end
   endgenerate

   // ==========================================
   // flags placed in enable layout
   logic [31:0] flag_layout;

   always_comb begin
      flag_layout = '0;
      for (int i = 0; i < `EVENT_COUNT; i++) begin
         flag_layout[event_bit(i)] = flag[i];
      end
   end

   // ==========================================
   // interrupt enable mask
   logic [31:0] interrupt_enable_mask;
   wire logic [31:0] next_interrupt_enable_mask;

   // [RULE2] stopped and error enables
   // [RULE3] per event enables
   assign next_interrupt_enable_mask = wr_data & `MASK_INT_LAYOUT;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         interrupt_enable_mask <= `RST_WORD;
      end else if (wr_int_enable) begin
         interrupt_enable_mask <= next_interrupt_enable_mask;
      end
   end

   // ==========================================
   // shortcuts
   wire logic [31:0] next_event_task_shortcuts;
   wire logic        write_suspend_en;
   wire logic        read_suspend_en;

   assign next_event_task_shortcuts = wr_data & `MASK_SHORTCUTS;

   // [RULE6] shortcut bits reset disabled
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         event_task_shortcuts <= `RST_WORD;
      end else if (wr_shortcuts) begin
         event_task_shortcuts <= next_event_task_shortcuts;
      end
   end

   assign write_suspend_en = event_task_shortcuts[`BIT_WRITE_SUSPEND];
   assign read_suspend_en  = event_task_shortcuts[`BIT_READ_SUSPEND];

   // [RULE6] command triggers suspend
   assign task_req.suspend = (events.write_cmd & write_suspend_en) |
                             (events.read_cmd & read_suspend_en);

   // ==========================================
   // interrupt line
   wire logic [31:0] pending;

   // [RULE7] flag and enable gate
   // [RULE4] write command gated
   // [RULE5] read command gated
   assign pending = flag_layout & interrupt_enable_mask;

   always_comb begin
      irq = |pending;
   end

   // ==========================================
   // read data
   logic [31:0]      flag_word;
   wire logic [31:0] next_rd_data;

   always_comb begin
      flag_word = '0;
      for (int i = 0; i < `EVENT_COUNT; i++) begin
         if (hit_flag[i]) begin
            flag_word[`BIT_FLAG_VALUE] = flag[i];
         end
      end
   end

   // unmapped addresses read as zero
   assign next_rd_data = !hit_any       ? `RST_WORD :
                         hit_shortcuts  ? event_task_shortcuts :
                         hit_int_enable ? interrupt_enable_mask :
                         hit_int_status ? flag_layout :
                                          flag_word;

   // data only in the cycle after the read strobe
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rd_data <= `RST_WORD;
      end else if (rd_stb) begin
         rd_data <= next_rd_data;
      end else begin
         rd_data <= `RST_WORD;
      end
   end

endmodule

// ### verilog/i2c_slave_event_irq_regs.svh
`ifndef I2C_SLAVE_EVENT_IRQ_REGS_SVH
`define I2C_SLAVE_EVENT_IRQ_REGS_SVH

// ==========================================
// register byte offsets
`define OFS_STOPPED_FLAG     12'h104
`define OFS_ERROR_FLAG       12'h124
`define OFS_RX_BEGUN_FLAG    12'h14c
`define OFS_TX_BEGUN_FLAG    12'h150
`define OFS_WRITE_CMD_FLAG   12'h164
`define OFS_READ_CMD_FLAG    12'h168
`define OFS_SHORTCUTS        12'h200
`define OFS_INT_ENABLE       12'h300
`define OFS_INT_STATUS       12'h30c

// ==========================================
// field positions: event bits shared by enable and status layout, then shortcut bits and flag value bit
`define BIT_STOPPED          5'd1
`define BIT_ERROR            5'd9
`define BIT_RX_BEGUN         5'd19
`define BIT_TX_BEGUN         5'd20
`define BIT_WRITE_CMD        5'd25
`define BIT_READ_CMD         5'd26
`define BIT_WRITE_SUSPEND    5'd14
`define BIT_READ_SUSPEND     5'd15
`define BIT_FLAG_VALUE       5'd0

// ==========================================
// reset values and writable masks
`define RST_FLAG             1'b0
`define RST_WORD             32'h0000_0000
`define MASK_INT_LAYOUT      32'h0618_0202
`define MASK_SHORTCUTS       32'h0000_c000
`define EVENT_COUNT          6

`endif

// ### verilog/i2c_slave_event_pkg.sv
package i2c_slave_event_pkg;

   // one-cycle event strobes from the two_wire_slave protocol engine
   typedef struct packed {
      logic read_cmd;
      logic write_cmd;
      logic transmit_sequence_begun;
      logic receive_sequence_begun;
      logic error;
      logic stopped;
   } event_vec_t;

   // shortcut requests toward the task logic
   typedef struct packed {
      logic suspend;
   } task_req_t;

endpackage
